// ==== rtl/acp_device.sv ====
// Converter end of the serial control port with test-pattern selection.
//
// How it works
// - Both test pins low: live samples to encoder.
// - Low pin only: constant b5b5 alternating word.
// - High pin only: constant ff00 word.
// - Both pins high: fifteen-bit pseudo-random sequence.
// - Serial bits accepted only while select low.
// - Data sampled on each serial clock fall.
// - Every sixteenth fall commits frame to register.
// - Trailing partial frame bits are simply dropped.
// - Many frames allowed in one select period.
// - Frame is address byte then data byte.
// - Works at any slow or uneven clock.
// - Reset pulse restores all register defaults.
// - Soft reset bit restores defaults, self-clears.
// - Read-back mode blocks writes except its bit.
// - Read-back frame shifts register out on pin.
// - Controller captures read-back bits on falls.
// - Controller clears read-back bit to resume writes.
// - Controller waits after reset before selecting.
// - Distortion tuning bits at address two.
// - Parallel mode turns pins into test inputs.
`include "acp_regs.svh"
`default_nettype none
module acp_device
	import acp_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	acp_if.dev link,
	input wire logic [15:0] adc_sample_i,
	output logic [15:0] encoder_word_o,
	output logic readback_en_o,
	output logic [3:0] distortion_tune_bits_o,
	output logic parallel_mode_o
);

	// ========================================
	// Serial clock edge detection

	logic sclk_prev_q;
	logic active;
	logic fall;

	// The serial clock is a plain input; a fall is seen in the first cycle the pin reads low.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sclk_prev_q <= 1'b1;
		end else begin
			sclk_prev_q <= link.sclk;
		end
	end

	// Only a low select in serial mode opens the port.
	assign active = !link.mode_parallel && !link.sel_n;

	// Edges are counted, not timed, so any slow or uneven clock works.
	assign fall = active && sclk_prev_q && !link.sclk;

	// ========================================
	// Frame shifter

	logic [3:0] bit_cnt_q;
	logic [14:0] shift_q;
	logic commit;
	logic [15:0] frame;
	logic [7:0] frame_addr;
	logic [7:0] frame_data;
	logic [7:0] rd_addr;

	// Bit counter restarts with each select period and wraps per frame.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bit_cnt_q <= 4'h0;
		end else if (link.hw_reset || !active) begin
			bit_cnt_q <= 4'h0;
		end else if (fall) begin
			bit_cnt_q <= bit_cnt_q + 4'h1;
		end
	end

	// Incoming bits enter at the bottom, so the first bit ends up on top.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			shift_q <= 15'h0000;
		end else if (fall) begin
			shift_q <= {shift_q[13:0], link.data_in_or_test_sel_lo};
		end
	end

	// Complete frame as seen on the sixteenth fall.
	assign frame = {shift_q, link.data_in_or_test_sel_lo};
	assign frame_addr = frame[15:8];
	assign frame_data = frame[7:0];
	assign commit = fall && (bit_cnt_q == `ACP_FRAME_LAST);

	// Address as seen on the eighth fall, used to start read-back.
	assign rd_addr = {shift_q[6:0], link.data_in_or_test_sel_lo};

	// ========================================
	// Configuration registers

	logic readback_q;
	logic [7:0] tune_q;
	logic soft_reset;

	// Soft reset is honoured only while writes are open.
	assign soft_reset = commit && !readback_q && (frame_addr == `ACP_REG_CTRL) &&
		frame_data[`ACP_CTRL_SRESET];

	// Read-back enable: always writable, even while it blocks the rest.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			readback_q <= 1'b0;
		end else if (link.hw_reset) begin
			readback_q <= 1'b0;
		end else if (soft_reset) begin
			readback_q <= 1'b0;
		end else if (commit && (frame_addr == `ACP_REG_CTRL)) begin
			readback_q <= frame_data[`ACP_CTRL_READBACK];
		end
	end

	// Distortion tuning bits; bits outside the field never store.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tune_q <= `ACP_REG_RST;
		end else if (link.hw_reset) begin
			tune_q <= `ACP_REG_RST;
		end else if (soft_reset) begin
			tune_q <= `ACP_REG_RST;
		end else if (commit && !readback_q && (frame_addr == `ACP_REG_TUNE)) begin
			tune_q <= frame_data & `ACP_TUNE_MASK;
		end
	end

	// Plain views of the stored settings and the mode pin for the converter core.
	assign readback_en_o = readback_q;
	assign distortion_tune_bits_o = {tune_q[6:4], tune_q[0]};
	assign parallel_mode_o = link.mode_parallel;

	// ========================================
	// Read-back shifter

	logic [7:0] rd_shift_q;
	logic [7:0] rd_value;

	// Register contents as read back; the soft reset bit always reads zero.
	always_comb begin
		rd_value = 8'h00;
		case (rd_addr)
			`ACP_REG_CTRL: rd_value = {7'h00, readback_q};
			`ACP_REG_TUNE: rd_value = tune_q;
			default: rd_value = 8'h00;
		endcase
	end

	// Loaded after the eighth fall and shifted one fall at a time after.
	// Each bit changes just after the fall that the controller used for the
	// previous bit, so it is settled for a whole clock half before its own.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rd_shift_q <= 8'h00;
		end else if (link.hw_reset || !active) begin
			rd_shift_q <= 8'h00;
		end else if (fall && (bit_cnt_q == `ACP_ADDR_LAST)) begin
			rd_shift_q <= rd_value;
		end else if (fall) begin
			rd_shift_q <= {rd_shift_q[6:0], 1'b0};
		end
	end

	// The shared pin is driven only in a read-back select period.
	assign link.dev_out = rd_shift_q[7];
	assign link.dev_oe = active && readback_q;

	// ========================================
	// Encoder source selection

	acp_src_t src;
	logic [14:0] prbs_q;
	logic [30:0] prbs_next;

	// The two pins select a source only in parallel mode.
	always_comb begin
		src = ACP_SRC_LIVE;
		if (link.mode_parallel) begin
			src = acp_src_t'({link.readback_out_or_test_sel_hi, link.data_in_or_test_sel_lo});
		end
	end

	assign prbs_next = acp_prbs16(prbs_q);

	// Generator runs only while selected; the scrambler plays no part.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prbs_q <= `ACP_PRBS_SEED;
		end else if (link.hw_reset) begin
			prbs_q <= `ACP_PRBS_SEED;
		end else if (src == ACP_SRC_PRBS) begin
			prbs_q <= prbs_next[14:0];
		end
	end

	// Registered word to the encoder, one per clock.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			encoder_word_o <= 16'h0000;
		end else begin
			case (src)
				ACP_SRC_LIVE: encoder_word_o <= adc_sample_i;
				ACP_SRC_ALT: encoder_word_o <= `ACP_WORD_ALT;
				ACP_SRC_STEP: encoder_word_o <= `ACP_WORD_STEP;
				ACP_SRC_PRBS: encoder_word_o <= prbs_next[30:15];
				default: encoder_word_o <= adc_sample_i;
			endcase
		end
	end

endmodule
`default_nettype wire

// ==== rtl/acp_host.sv ====
// Controller end of the serial control port, driven from a software register port.
`include "acp_regs.svh"
`default_nettype none
module acp_host
	import acp_pkg::*;
#(
	parameter int HALF_CYC = 1
)
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	acp_if.host link,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic we_i,
	input wire logic re_i,
	output logic [31:0] rdata_o
);

	// ========================================
	// Timing counts

	localparam logic [7:0] RST_CYC = 8'(`ACP_NS_TO_CYC(`ACP_RST_PULSE_NS));
	localparam logic [7:0] WAIT_CYC = 8'(`ACP_NS_TO_CYC(`ACP_RST_TO_SEL_NS));
	localparam logic [7:0] HALF = 8'(HALF_CYC);
	localparam logic [5:0] FRAME_FALLS = 6'(`ACP_FRAME_W);
	localparam logic [5:0] TRAIL_FALLS = 6'(`ACP_ADDR_W);

	// ========================================
	// Software registers

	logic [15:0] frame_q;
	logic [2:0] pins_q;
	logic [7:0] rd_data_q;
	logic done_q;
	logic busy;
	logic go_frame;
	logic go_reset;
	logic finish;
	acp_hstate_t state_q;

	assign busy = (state_q != ACP_H_IDLE);
	assign go_frame = we_i && (addr_i == `ACP_HREG_CMD) && wdata_i[`ACP_CMD_FRAME] && !busy;
	assign go_reset = we_i && (addr_i == `ACP_HREG_CMD) && wdata_i[`ACP_CMD_HWRST] && !busy;

	// Frame to send: address byte on top, sent first.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			frame_q <= 16'h0000;
		end else if (we_i && (addr_i == `ACP_HREG_FRAME)) begin
			frame_q <= wdata_i[15:0];
		end
	end

	// Mode and test-select pin levels.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pins_q <= 3'h0;
		end else if (we_i && (addr_i == `ACP_HREG_PINS)) begin
			pins_q <= wdata_i[2:0];
		end
	end

	// Done flag: a finishing frame wins over a clear in the same cycle.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			done_q <= 1'b0;
		end else if (finish) begin
			done_q <= 1'b1;
		end else if (we_i && (addr_i == `ACP_HREG_STATUS) && wdata_i[`ACP_ST_DONE]) begin
			done_q <= 1'b0;
		end
	end

	// Read data stand in the cycle after the strobe and only there.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_o <= 32'h0000_0000;
		end else if (re_i) begin
			case (addr_i)
				`ACP_HREG_FRAME: rdata_o <= {16'h0000, frame_q};
				`ACP_HREG_STATUS: rdata_o <= {16'h0000, rd_data_q, 6'h00, done_q, busy};
				`ACP_HREG_PINS: rdata_o <= {29'h0, pins_q};
				default: rdata_o <= 32'h0000_0000;
			endcase
		end else begin
			rdata_o <= 32'h0000_0000;
		end
	end

	// ========================================
	// Pin sequencer

	logic [7:0] tmr_q;
	logic [5:0] cnt_q;
	logic [5:0] end_q;
	logic [15:0] tx_q;
	logic [7:0] rx_q;
	logic sclk_q;
	logic sel_n_q;
	logic serial_data_in_q;
	logic hw_reset_q;
	logic step;

	assign step = (tmr_q == 8'h00);
	assign finish = (state_q == ACP_H_TAIL) && step;

	// One state per pin phase; the timer paces every phase.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q <= ACP_H_IDLE;
			tmr_q <= 8'h00;
			cnt_q <= 6'h00;
			end_q <= 6'h00;
			tx_q <= 16'h0000;
			rx_q <= 8'h00;
			sclk_q <= 1'b1;
			sel_n_q <= 1'b1;
			serial_data_in_q <= 1'b0;
			hw_reset_q <= 1'b0;
		end else if (state_q == ACP_H_IDLE) begin
			if (go_reset) begin
				state_q <= ACP_H_RSTP;
				hw_reset_q <= 1'b1;
				tmr_q <= RST_CYC - 8'h01;
			end else if (go_frame) begin
				state_q <= ACP_H_LEAD;
				sel_n_q <= 1'b0;
				serial_data_in_q <= frame_q[15];
				tx_q <= {frame_q[14:0], 1'b0};
				cnt_q <= 6'h00;
				// Falls in this select period: one frame, a second chained one, a trailing byte.
				end_q <= FRAME_FALLS + (wdata_i[`ACP_CMD_CHAIN] ? FRAME_FALLS : 6'h00) +
					(wdata_i[`ACP_CMD_TRAIL] ? TRAIL_FALLS : 6'h00);
				tmr_q <= HALF - 8'h01;
			end
		end else if (!step) begin
			tmr_q <= tmr_q - 8'h01;
		end else begin
			tmr_q <= HALF - 8'h01;
			case (state_q)
				ACP_H_RSTP: begin
					state_q <= ACP_H_RWAIT;
					hw_reset_q <= 1'b0;
					tmr_q <= WAIT_CYC - 8'h01;
				end
				ACP_H_RWAIT: begin
					state_q <= ACP_H_IDLE;
				end
				ACP_H_LEAD, ACP_H_HIGH: begin
					state_q <= ACP_H_LOW;
					sclk_q <= 1'b0;
					cnt_q <= cnt_q + 6'h01;
					if (cnt_q[3]) begin
						rx_q <= {rx_q[6:0], link.readback_out_or_test_sel_hi};
					end
				end
				ACP_H_LOW: begin
					sclk_q <= 1'b1;
					// A chained frame restarts from the frame register, which software may refill meanwhile.
					if (cnt_q == end_q) begin
						state_q <= ACP_H_TAIL;
					end else if (cnt_q[3:0] == 4'h0) begin
						state_q <= ACP_H_HIGH;
						serial_data_in_q <= frame_q[15];
						tx_q <= {frame_q[14:0], 1'b0};
					end else begin
						state_q <= ACP_H_HIGH;
						serial_data_in_q <= tx_q[15];
						tx_q <= {tx_q[14:0], 1'b0};
					end
				end
				ACP_H_TAIL: begin
					state_q <= ACP_H_IDLE;
					sel_n_q <= 1'b1;
				end
				default: begin
					state_q <= ACP_H_IDLE;
				end
			endcase
		end
	end

	// Captured read-back byte, kept once the frame is over.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rd_data_q <= 8'h00;
		end else if (finish) begin
			rd_data_q <= rx_q;
		end
	end

	// ========================================
	// Pin drive

	// In parallel mode the data pin and the shared pin carry test selects.
	assign link.sclk = sclk_q;
	assign link.sel_n = sel_n_q;
	assign link.hw_reset = hw_reset_q;
	assign link.mode_parallel = pins_q[`ACP_PIN_PAR];
	assign link.data_in_or_test_sel_lo = pins_q[`ACP_PIN_PAR] ? pins_q[`ACP_PIN_TLO] : serial_data_in_q;
	assign link.host_out = pins_q[`ACP_PIN_THI];
	assign link.host_oe = pins_q[`ACP_PIN_PAR];

endmodule
`default_nettype wire

// ==== rtl/acp_host_end_marker.sv ====
// Intentionally empty compilation unit.
`default_nettype none
`default_nettype wire

// ==== rtl/acp_if.sv ====
// Pin-level carrier between the converter control port and its controller.
`default_nettype none
interface acp_if;
	logic sclk;
	logic sel_n;
	logic data_in_or_test_sel_lo;
	logic hw_reset;
	logic mode_parallel;
	logic dev_out;
	logic dev_oe;
	logic host_out;
	logic host_oe;
	logic readback_out_or_test_sel_hi;

	// Shared pin level: the enabled driver wins, the pin idles low.
	assign readback_out_or_test_sel_hi = dev_oe ? dev_out : (host_oe ? host_out : 1'b0);

	modport dev (
		input sclk, sel_n, data_in_or_test_sel_lo, hw_reset, mode_parallel,
		input readback_out_or_test_sel_hi,
		output dev_out, dev_oe
	);
	modport host (
		output sclk, sel_n, data_in_or_test_sel_lo, hw_reset, mode_parallel,
		output host_out, host_oe,
		input readback_out_or_test_sel_hi
	);
endinterface
`default_nettype wire

// ==== rtl/acp_pkg.sv ====
// Types shared by both ends of the converter control port.
`default_nettype none
package acp_pkg;
	// Encoder source chosen by the two test-select pins.
	typedef enum logic [1:0] {
		ACP_SRC_LIVE = 2'h0,
		ACP_SRC_ALT = 2'h1,
		ACP_SRC_STEP = 2'h2,
		ACP_SRC_PRBS = 2'h3
	} acp_src_t;

	// Controller sequencer states.
	typedef enum logic [6:0] {
		ACP_H_IDLE = 7'h01,
		ACP_H_RSTP = 7'h02,
		ACP_H_RWAIT = 7'h04,
		ACP_H_LEAD = 7'h08,
		ACP_H_LOW = 7'h10,
		ACP_H_HIGH = 7'h20,
		ACP_H_TAIL = 7'h40
	} acp_hstate_t;

	// Sixteen steps of the 1+x^14+x^15 generator: word in [30:15], state in [14:0].
	function automatic logic [30:0] acp_prbs16(input logic [14:0] s);
		logic [14:0] st;
		logic [15:0] w;
		st = s;
		w = 16'h0000;
		for (int i = 0; i < 16; i++) begin
			w = {w[14:0], st[14] ^ st[13]};
			st = {st[13:0], st[14] ^ st[13]};
		end
		return {w, st};
	endfunction
endpackage
`default_nettype wire

// ==== rtl/acp_regs.svh ====
// Register map, field positions and timing constants of the converter control port.
`ifndef ACP_REGS_SVH
`define ACP_REGS_SVH
// ========================================
// Device register map
`define ACP_ADDR_W 8
`define ACP_DATA_W 8
`define ACP_FRAME_W 16
`define ACP_FRAME_LAST 4'hf
`define ACP_ADDR_LAST 4'h7
`define ACP_REG_CTRL 8'h00
`define ACP_REG_TUNE 8'h02
`define ACP_CTRL_READBACK 0
`define ACP_CTRL_SRESET 1
`define ACP_TUNE_MASK 8'h71
`define ACP_REG_RST 8'h00
// ========================================
// Encoder test words
`define ACP_WORD_ALT 16'hb5b5
`define ACP_WORD_STEP 16'hff00
`define ACP_PRBS_SEED 15'h7fff
// ========================================
// Controller registers on the software port
`define ACP_HREG_CMD 8'h00
`define ACP_HREG_FRAME 8'h04
`define ACP_HREG_STATUS 8'h08
`define ACP_HREG_PINS 8'h0c
`define ACP_CMD_FRAME 0
`define ACP_CMD_HWRST 1
`define ACP_CMD_CHAIN 2
`define ACP_CMD_TRAIL 3
`define ACP_ST_BUSY 0
`define ACP_ST_DONE 1
`define ACP_PIN_TLO 0
`define ACP_PIN_THI 1
`define ACP_PIN_PAR 2
// ========================================
// Timing
`define ACP_CLK_PERIOD_NS 100
`define ACP_RST_PULSE_NS 10
`define ACP_RST_TO_SEL_NS 100
`define ACP_NS_TO_CYC(ns) (((ns) + `ACP_CLK_PERIOD_NS - 1) / `ACP_CLK_PERIOD_NS)
`endif

// ==== test/acp_monitor.sv ====
// Concurrent checks on the wires between the converter port and its controller.
`default_nettype none
module acp_monitor (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic sclk_i,
	input wire logic sel_n_i,
	input wire logic data_in_or_test_sel_lo_i,
	input wire logic hw_reset_i,
	input wire logic mode_parallel_i,
	input wire logic dev_oe_i
);
	timeunit 1ns;
	timeprecision 1ns;
	logic sclk_q;
	logic [5:0] fall_q;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	// ========================================
	// Helper: counts serial clock falls inside one select period.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sclk_q <= 1'h1;
			fall_q <= 6'h00;
		end else begin
			sclk_q <= sclk_i;
			if (sel_n_i) begin
				fall_q <= 6'h00;
			end else if (sclk_q && !sclk_i) begin
				fall_q <= fall_q + 6'h01;
			end
		end
	end
	// ========================================
	// Properties.
	property p_idle_clk;
		sel_n_i |-> sclk_i;
	endproperty
	a_idle_clk: assert property (p_idle_clk) else $error("Serial clock low outside a frame.");
	property p_fall_in_sel;
		$fell(sclk_i) |-> !sel_n_i;
	endproperty
	a_fall_in_sel: assert property (p_fall_in_sel) else $error("Clock fall without select.");
	// Chained frames and a trailing part are legal; a period without one whole frame is not.
	property p_frame_len;
		$rose(sel_n_i) |-> fall_q >= 6'h10;
	endproperty
	a_frame_len: assert property (p_frame_len) else $error("Select period holds no whole frame.");
	property p_data_hold;
		!sel_n_i && !$fell(sel_n_i) && !$rose(sclk_i) && !mode_parallel_i |-> $stable(data_in_or_test_sel_lo_i);
	endproperty
	a_data_hold: assert property (p_data_hold) else $error("Data moved away from a clock rise.");
	property p_hw_pulse;
		$rose(hw_reset_i) |=> !hw_reset_i;
	endproperty
	a_hw_pulse: assert property (p_hw_pulse) else $error("Reset pulse longer than one cycle.");
	property p_hw_gap;
		hw_reset_i |-> sel_n_i ##1 sel_n_i;
	endproperty
	a_hw_gap: assert property (p_hw_gap) else $error("Select too soon after reset pulse.");
	property p_oe_sel;
		dev_oe_i |-> !sel_n_i;
	endproperty
	a_oe_sel: assert property (p_oe_sel) else $error("Device drives pin without select.");
	property p_oe_par;
		mode_parallel_i |-> !dev_oe_i;
	endproperty
	a_oe_par: assert property (p_oe_par) else $error("Device drives pin in parallel mode.");
endmodule
`default_nettype wire

// ==== test/tb_top.sv ====
// Self-checking bench joining both ends of the converter control port.
`include "acp_regs.svh"
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 1'h0;
	logic rst_n_i = 1'h0;
	logic [7:0] addr_i = 8'h00;
	logic [31:0] wdata_i = 32'h0;
	logic we_i = 1'h0;
	logic re_i = 1'h0;
	logic [31:0] rdata_o;
	logic [15:0] adc_sample_i = 16'h1234;
	logic [15:0] encoder_word_o;
	logic readback_en_o;
	logic [3:0] tune_o;
	logic par_o;
	logic [15:0] cap;
	logic [31:0] rd_q;
	int num_errors = 0;
	int num_checks = 0;
	acp_if link_if ();
	// ========================================
	// Clock, both ends and the checker.
	always #50 clk_i = ~clk_i;
	acp_host #(.HALF_CYC(2)) acp_host_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .link(link_if), .addr_i(addr_i),
		.wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o));
	acp_device acp_device_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .link(link_if), .adc_sample_i(adc_sample_i),
		.encoder_word_o(encoder_word_o), .readback_en_o(readback_en_o), .distortion_tune_bits_o(tune_o),
		.parallel_mode_o(par_o));
	acp_monitor acp_monitor_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .sclk_i(link_if.sclk),
		.sel_n_i(link_if.sel_n), .data_in_or_test_sel_lo_i(link_if.data_in_or_test_sel_lo),
		.hw_reset_i(link_if.hw_reset), .mode_parallel_i(link_if.mode_parallel), .dev_oe_i(link_if.dev_oe));
	// Shifts in the data line at each serial clock fall of a frame.
	always @(negedge link_if.sclk) begin
		if (!link_if.sel_n) begin
			cap <= {cap[14:0], link_if.data_in_or_test_sel_lo};
		end
	end
	// ========================================
	// Shared tasks.
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		we_i <= 1'h1;
		@(posedge clk_i);
		we_i <= 1'h0;
	endtask
	// Read data stand only in the cycle after the strobe.
	task automatic rd(input logic [7:0] a);
		@(posedge clk_i);
		addr_i <= a;
		re_i <= 1'h1;
		@(posedge clk_i);
		re_i <= 1'h0;
		#1 rd_q = rdata_o;
	endtask
	task automatic wait_idle();
		for (int n = 0; n < 300; n++) begin
			rd(`ACP_HREG_STATUS);
			if (rd_q[0] === 1'h0) return;
		end
		num_errors++;
		give_verdict();
	endtask
	task automatic frame(input logic [7:0] a, input logic [7:0] d);
		wr(`ACP_HREG_FRAME, {16'h0, a, d});
		wr(`ACP_HREG_CMD, 32'h1);
		wait_idle();
		check("done", {31'h0, rd_q[1]}, 32'h1);
		check("frame bits", {16'h0, cap}, {16'h0, a, d});
		wr(`ACP_HREG_STATUS, 32'h2);
	endtask
	function automatic logic [15:0] prbs_next(input logic [14:0] s);
		logic [14:0] st;
		logic [15:0] w;
		st = s;
		w = 16'h0;
		for (int i = 0; i < 16; i++) begin
			w = {w[14:0], st[14] ^ st[13]};
			st = {st[13:0], st[14] ^ st[13]};
		end
		return w;
	endfunction
	// ========================================
	// Scenarios.
	task automatic s_reset();
		repeat (3) @(posedge clk_i);
		#1;
		check("readback", {31'h0, readback_en_o}, 32'h0);
		check("tune", {28'h0, tune_o}, 32'h0);
		check("live", {16'h0, encoder_word_o}, {16'h0, adc_sample_i});
		check("par", {31'h0, par_o}, 32'h0);
		rd(8'h10);
		check("unmapped", rd_q, 32'h0);
	endtask
	task automatic s_write();
		frame(`ACP_REG_TUNE, 8'hff);
		check("tune", {28'h0, tune_o}, 32'hf);
		frame(`ACP_REG_TUNE, 8'h50);
		check("tune", {28'h0, tune_o}, 32'ha);
		frame(8'h05, 8'hff);
		check("tune", {28'h0, tune_o}, 32'ha);
	endtask
	task automatic s_readback();
		frame(`ACP_REG_CTRL, 8'h01);
		check("readback", {31'h0, readback_en_o}, 32'h1);
		frame(`ACP_REG_TUNE, 8'h00);
		check("tune", {28'h0, tune_o}, 32'ha);
		check("read byte", {24'h0, rd_q[15:8]}, 32'h50);
		frame(`ACP_REG_CTRL, 8'h03);
		check("tune", {28'h0, tune_o}, 32'ha);
		frame(`ACP_REG_CTRL, 8'h00);
		check("read byte", {24'h0, rd_q[15:8]}, 32'h01);
		check("readback", {31'h0, readback_en_o}, 32'h0);
		frame(`ACP_REG_TUNE, 8'h71);
		check("tune", {28'h0, tune_o}, 32'hf);
	endtask
	// Two frames in one select period, then one frame with a trailing address byte.
	task automatic s_chain();
		wr(`ACP_HREG_FRAME, {16'h0, `ACP_REG_TUNE, 8'h71});
		wr(`ACP_HREG_CMD, 32'h5);
		wr(`ACP_HREG_FRAME, {16'h0, `ACP_REG_CTRL, 8'h01});
		wait_idle();
		check("chain tune", {28'h0, tune_o}, 32'hf);
		check("chain readback", {31'h0, readback_en_o}, 32'h1);
		check("chain bits", {16'h0, cap}, {16'h0, `ACP_REG_CTRL, 8'h01});
		rd(`ACP_HREG_FRAME);
		check("frame reg", rd_q, {16'h0, `ACP_REG_CTRL, 8'h01});
		wr(`ACP_HREG_STATUS, 32'h2);
		frame(`ACP_REG_CTRL, 8'h00);
		check("readback", {31'h0, readback_en_o}, 32'h0);
		wr(`ACP_HREG_FRAME, {16'h0, `ACP_REG_TUNE, 8'h50});
		wr(`ACP_HREG_CMD, 32'h9);
		wait_idle();
		check("trail tune", {28'h0, tune_o}, 32'ha);
		check("trail bits", {16'h0, cap}, {16'h0, 8'h50, `ACP_REG_TUNE});
		wr(`ACP_HREG_STATUS, 32'h2);
		frame(`ACP_REG_TUNE, 8'h01);
		check("after trail", {28'h0, tune_o}, 32'h1);
	endtask
	task automatic s_resets();
		frame(`ACP_REG_CTRL, 8'h02);
		check("tune", {28'h0, tune_o}, 32'h0);
		frame(`ACP_REG_CTRL, 8'h01);
		frame(`ACP_REG_CTRL, 8'h00);
		check("read byte", {24'h0, rd_q[15:8]}, 32'h01);
		frame(`ACP_REG_TUNE, 8'h71);
		wr(`ACP_HREG_CMD, 32'h2);
		wait_idle();
		check("tune", {28'h0, tune_o}, 32'h0);
		frame(`ACP_REG_TUNE, 8'h01);
		check("tune", {28'h0, tune_o}, 32'h1);
	endtask
	task automatic s_parallel();
		logic [47:0] tbl;
		logic [15:0] w1;
		tbl = {16'hff00, 16'hb5b5, adc_sample_i};
		for (int c = 0; c < 4; c++) begin
			wr(`ACP_HREG_PINS, {29'h0, 1'h1, 2'(c)});
			rd(`ACP_HREG_PINS);
			check("pins reg", rd_q, {29'h0, 1'h1, 2'(c)});
			repeat (4) @(posedge clk_i);
			#1 w1 = encoder_word_o;
			check("par", {31'h0, par_o}, 32'h1);
			check("pin", {31'h0, link_if.readback_out_or_test_sel_hi}, 32'(c / 2));
			if (c < 3) begin
				check("word", {16'h0, w1}, {16'h0, tbl[c * 16 +: 16]});
			end else begin
				@(posedge clk_i);
				#1;
				check("prbs", {16'h0, encoder_word_o}, {16'h0, prbs_next(w1[14:0])});
			end
		end
		wr(`ACP_HREG_PINS, 32'h0);
	endtask
	// ========================================
	// Main sequence.
	initial begin
		repeat (2) @(posedge clk_i);
		rst_n_i <= 1'h1;
		s_reset();
		s_write();
		s_readback();
		s_chain();
		s_resets();
		s_parallel();
		give_verdict();
	end
endmodule
`default_nettype wire
